// ===== color_meas_ctrl.v
// measurement sequencer, result store and threshold logic
//
// The implementer's own choices: the strobed register port and the register offsets.
`timescale 1ns/1ps
`include "color_meas_defs.vh"
module color_meas_ctrl #(
   parameter DW = 16,
   parameter CONV_BASE = `CONV_BASE_CYC,
   parameter RANGE_RESET = `RANGE_RESET_CYC,
   parameter WAKE = `WAKE_CYC
) (
   // clock and reset
   input wire ref_clk,
   input wire arst_n,
   // register port
   input wire [3:0] addr,
   input wire [31:0] wdata,
   input wire wr_stb,
   input wire rd_stb,
   output reg [31:0] rdata_ff,
   // analog front end
   output wire afe_power,
   output wire [1:0] afe_channel,
   output wire afe_range_reset,
   input wire [DW-1:0] afe_sample,
   input wire [3:0] afe_range,
   // alert pin, open drain, oe low drives low
   input wire alert_in,
   output wire alert_out,
   output wire alert_oe_n
);
   localparam ST_IDLE = 3'h0;
   localparam ST_WAKE = 3'h1;
   localparam ST_RRST = 3'h2;
   localparam ST_CONV = 3'h3;
   localparam ST_DONE = 3'h4;
   localparam [31:0] PULSE_FULL = `ALERT_PULSE_CYC;

   reg [1:0] mode_ff;
   reg [3:0] conv_ff;
   reg trig_ff;
   reg [1:0] thr_sel_ff;
   reg [1:0] fault_cfg_ff;
   reg [DW-1:0] thr_lo_ff;
   reg [DW-1:0] thr_hi_ff;
   reg flag_lo_ff;
   reg flag_hi_ff;
   reg [1:0] alert_fn_ff;
   reg alert_dir_in_ff;
   reg fast_wake_hold_ff;
   reg alert_pol_ff;

   reg [2:0] st_ff;
   reg [1:0] run_mode_ff;
   reg [1:0] ch_ff;
   reg [31:0] tmr_ff;
   reg [DW-1:0] result_ff [0:3];
   reg [3:0] range_ff [0:3];
   reg [3:0] per_channel_sample_count_ff [0:3];
   reg [3:0] per_channel_check_bits_ff [0:3];
   reg [3:0] fault_run_ff;
   reg [7:0] pulse_ff;
   reg alert_in_d_ff;
   reg powered_ff;

   wire wr_trig = wr_stb && addr == `REG_TRIG && wdata[0];
   wire pin_trig = alert_dir_in_ff && alert_in && !alert_in_d_ff;
   wire one_shot = mode_ff == `MODE_FORCED || mode_ff == `MODE_ONESHOT;
   wire start = mode_ff == `MODE_CONT || (one_shot && (trig_ff || pin_trig));
   wire [31:0] conv_cyc = CONV_BASE * ({28'h0, conv_ff} + 32'h1);
   wire conv_end = st_ff == ST_CONV && tmr_ff == 32'h0;
   wire [DW-1:0] sel_val = (ch_ff == thr_sel_ff) ? afe_sample :
      result_ff[thr_sel_ff];
   wire is_lo = sel_val < thr_lo_ff;
   wire is_hi = sel_val > thr_hi_ff;
   wire [3:0] fault_need = 4'h1 << fault_cfg_ff;
   wire [3:0] nxt_run = fault_run_ff + 4'h1;
   wire fault_hit = conv_end && ch_ff == thr_sel_ff && (is_lo || is_hi);

   assign afe_power = powered_ff;
   assign afe_channel = ch_ff;
   assign afe_range_reset = st_ff == ST_RRST;

   // check bits: fold of result and counter
   function [3:0] check_fold;
      input [DW-1:0] v;
      input [3:0] c;
      integer i;
      begin
         check_fold = c;
         for (i = 0; i < DW; i = i + 1) begin
            check_fold[i % 4] = check_fold[i % 4] ^ v[i];
         end
      end
   endfunction

   // sequencer
   always @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         st_ff <= ST_IDLE;
         run_mode_ff <= `MODE_OFF;
         ch_ff <= 2'h0;
         tmr_ff <= 32'h0;
         powered_ff <= 1'b0;
      end else begin
         case (st_ff)
            ST_IDLE: begin
               powered_ff <= fast_wake_hold_ff && one_shot;
               if (start) begin
                  run_mode_ff <= mode_ff;
                  ch_ff <= 2'h0;
                  powered_ff <= 1'b1;
                  if (powered_ff) begin
                     st_ff <= (mode_ff == `MODE_FORCED) ? ST_RRST : ST_CONV;
                     tmr_ff <= (mode_ff == `MODE_FORCED) ?
                        RANGE_RESET - 1 : conv_cyc - 32'h1;
                  end else begin
                     st_ff <= ST_WAKE;
                     tmr_ff <= WAKE - 1;
                  end
               end
            end
            ST_WAKE: begin
               if (tmr_ff == 32'h0) begin
                  st_ff <= (run_mode_ff == `MODE_FORCED) ? ST_RRST : ST_CONV;
                  tmr_ff <= (run_mode_ff == `MODE_FORCED) ?
                     RANGE_RESET - 1 : conv_cyc - 32'h1;
               end else begin
                  tmr_ff <= tmr_ff - 32'h1;
               end
            end
            ST_RRST: begin
               if (tmr_ff == 32'h0) begin
                  st_ff <= ST_CONV;
                  tmr_ff <= conv_cyc - 32'h1;
               end else begin
                  tmr_ff <= tmr_ff - 32'h1;
               end
            end
            ST_CONV: begin
               if (tmr_ff == 32'h0) begin
                  ch_ff <= ch_ff + 2'h1;
                  tmr_ff <= conv_cyc - 32'h1;
                  if (run_mode_ff != `MODE_CONT && ch_ff == 2'h3) begin
                     st_ff <= ST_DONE;
                  end else if (run_mode_ff == `MODE_CONT &&
                     mode_ff != `MODE_CONT) begin
                     st_ff <= ST_IDLE;
                  end
               end else begin
                  tmr_ff <= tmr_ff - 32'h1;
               end
            end
            ST_DONE: begin
               st_ff <= ST_IDLE;
               powered_ff <= fast_wake_hold_ff;
            end
            default: st_ff <= ST_IDLE;
         endcase
      end
   end

   // results, ranges, counters and check bits
   integer k;
   always @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         for (k = 0; k < 4; k = k + 1) begin
            result_ff[k] <= {DW{1'b0}};
            range_ff[k] <= 4'h0;
            per_channel_sample_count_ff[k] <= 4'h0;
            per_channel_check_bits_ff[k] <= 4'h0;
         end
      end else begin
         if (st_ff == ST_RRST) begin
            for (k = 0; k < 4; k = k + 1) begin
               range_ff[k] <= 4'h0;
            end
         end
         if (conv_end) begin
            result_ff[ch_ff] <= afe_sample;
            range_ff[ch_ff] <= afe_range;
            per_channel_sample_count_ff[ch_ff] <=
               per_channel_sample_count_ff[ch_ff] + 4'h1;
            per_channel_check_bits_ff[ch_ff] <= check_fold(afe_sample,
               per_channel_sample_count_ff[ch_ff] + 4'h1);
         end
      end
   end

   // threshold faults and flags
   always @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         fault_run_ff <= 4'h0;
         flag_lo_ff <= 1'b0;
         flag_hi_ff <= 1'b0;
      end else begin
         if (conv_end && ch_ff == thr_sel_ff) begin
            if (fault_hit) begin
               fault_run_ff <= (nxt_run >= fault_need) ? fault_need : nxt_run;
            end else begin
               fault_run_ff <= 4'h0;
            end
         end
         // set beats the read clear
         if (fault_hit && nxt_run >= fault_need) begin
            flag_lo_ff <= is_lo;
            flag_hi_ff <= is_hi;
         end else if (rd_stb && addr == `REG_FLAGS) begin
            flag_lo_ff <= 1'b0;
            flag_hi_ff <= 1'b0;
         end
      end
   end

   // alert pulse and trigger pin edge
   always @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         pulse_ff <= 8'h0;
         alert_in_d_ff <= 1'b0;
      end else begin
         alert_in_d_ff <= alert_in;
         if (conv_end && !alert_dir_in_ff &&
            (alert_fn_ff == `ALERT_EACH ||
            (alert_fn_ff == `ALERT_SET && ch_ff == 2'h3))) begin
            pulse_ff <= PULSE_FULL[7:0];
         end else if (pulse_ff != 8'h0) begin
            pulse_ff <= pulse_ff - 8'h1;
         end
      end
   end

   wire alert_act = (alert_fn_ff == `ALERT_FAULT) ? (flag_lo_ff | flag_hi_ff)
      : (pulse_ff != 8'h0);
   wire pin_low = !alert_dir_in_ff && (alert_act ^ alert_pol_ff);
   assign alert_out = 1'b0;
   assign alert_oe_n = !pin_low;

   // register writes
   always @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         mode_ff <= `MODE_OFF;
         conv_ff <= `CONV_RST;
         trig_ff <= 1'b0;
         thr_sel_ff <= 2'h0;
         fault_cfg_ff <= `FAULT_CNT_RST;
         thr_lo_ff <= {DW{1'b0}};
         thr_hi_ff <= {DW{1'b1}};
         alert_fn_ff <= `ALERT_FAULT;
         alert_dir_in_ff <= 1'b0;
         fast_wake_hold_ff <= 1'b0;
         alert_pol_ff <= 1'b0;
      end else begin
         if (st_ff == ST_DONE) begin
            trig_ff <= 1'b0;
         end else if (st_ff == ST_IDLE && pin_trig) begin
            trig_ff <= 1'b0;
         end
         if (wr_trig && one_shot) begin
            trig_ff <= 1'b1;
         end
         if (wr_stb) begin
            case (addr)
               `REG_MODE: begin
                  mode_ff <= wdata[1:0];
                  fast_wake_hold_ff <= wdata[2];
               end
               `REG_CONV: conv_ff <= wdata[3:0];
               `REG_THR_CFG: begin
                  thr_sel_ff <= wdata[1:0];
                  fault_cfg_ff <= wdata[3:2];
               end
               `REG_THR_LO: thr_lo_ff <= wdata[DW-1:0];
               `REG_THR_HI: thr_hi_ff <= wdata[DW-1:0];
               `REG_ALERT: begin
                  alert_fn_ff <= wdata[1:0];
                  alert_dir_in_ff <= wdata[2];
                  alert_pol_ff <= wdata[3];
               end
               default: ;
            endcase
         end
      end
   end

   // register reads
   always @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         rdata_ff <= 32'h0;
      end else if (rd_stb) begin
         case (addr)
            `REG_MODE: rdata_ff <= {29'h0, fast_wake_hold_ff, mode_ff};
            `REG_CONV: rdata_ff <= {28'h0, conv_ff};
            `REG_TRIG: rdata_ff <= {29'h0, st_ff == ST_IDLE, powered_ff,
               trig_ff};
            `REG_THR_CFG: rdata_ff <= {28'h0, fault_cfg_ff, thr_sel_ff};
            `REG_THR_LO: rdata_ff <= {{(32-DW){1'b0}}, thr_lo_ff};
            `REG_THR_HI: rdata_ff <= {{(32-DW){1'b0}}, thr_hi_ff};
            `REG_FLAGS: rdata_ff <= {30'h0, flag_hi_ff, flag_lo_ff};
            `REG_ALERT: rdata_ff <= {28'h0, alert_pol_ff, alert_dir_in_ff,
               alert_fn_ff};
            default: begin
               if (addr >= `REG_RES0 && addr <= `REG_RES0 + 4'h3) begin
                  rdata_ff <= {range_ff[addr[1:0]],
                     per_channel_check_bits_ff[addr[1:0]],
                     per_channel_sample_count_ff[addr[1:0]],
                     {(20-DW){1'b0}}, result_ff[addr[1:0]]};
               end else begin
                  rdata_ff <= 32'h0;
               end
            end
         endcase
      end else begin
         rdata_ff <= 32'h0;
      end
   end

endmodule

// ===== color_meas_defs.vh
// constants for the colour sensor measurement control block
`ifndef COLOR_MEAS_DEFS_VH
`define COLOR_MEAS_DEFS_VH
// register indices
`define REG_MODE 4'h0
`define REG_CONV 4'h1
`define REG_TRIG 4'h2
`define REG_THR_CFG 4'h3
`define REG_THR_LO 4'h4
`define REG_THR_HI 4'h5
`define REG_FLAGS 4'h6
`define REG_ALERT 4'h7
`define REG_RES0 4'h8
// modes
`define MODE_OFF 2'h0
`define MODE_FORCED 2'h1
`define MODE_ONESHOT 2'h2
`define MODE_CONT 2'h3
// alert function codes
`define ALERT_FAULT 2'h0
`define ALERT_EACH 2'h1
`define ALERT_SET 2'h3
// timing in ns and in clock cycles, at a 25 ns clock period
`define CLK_PERIOD_NS 25
`define ALERT_PULSE_NS 1000
`define ALERT_PULSE_CYC (`ALERT_PULSE_NS / `CLK_PERIOD_NS)
`define RANGE_RESET_NS 500000
`define RANGE_RESET_CYC ((`RANGE_RESET_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define WAKE_NS 100000
`define WAKE_CYC ((`WAKE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define CONV_BASE_CYC 24000
// reset values
`define CONV_RST 4'h0
`define FAULT_CNT_RST 2'h0
`endif

// ===== color_meas_checker.sv
// assertions on the measurement control ports
`timescale 1ns/1ps
`include "color_meas_defs.vh"
module color_meas_checker #(
   parameter CONV_BASE = 4,
   parameter RANGE_RESET = 3
) (
   // clock, reset, register port
   input wire ref_clk,
   input wire arst_n,
   input wire [3:0] addr,
   input wire [31:0] wdata,
   input wire wr_stb,
   input wire rd_stb,
   input wire [31:0] rdata_ff,
   // front end and alert
   input wire afe_power,
   input wire [1:0] afe_channel,
   input wire afe_range_reset,
   input wire alert_oe_n
);
   reg [1:0] mode_ff, fn_ff, ch_ff;
   reg pol_ff;
   reg [3:0] code_ff;
   reg [15:0] lo_ff, rr_ff, low_ff, hold_ff;
   always @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         mode_ff <= 2'h0;
         fn_ff <= 2'h0;
         pol_ff <= 1'b0;
         ch_ff <= 2'h0;
         code_ff <= 4'h0;
         lo_ff <= 16'h0;
         rr_ff <= 16'h0;
         low_ff <= 16'h0;
         hold_ff <= 16'h0;
      end else begin
         if (wr_stb && addr == `REG_MODE) mode_ff <= wdata[1:0];
         if (wr_stb && addr == `REG_ALERT) fn_ff <= wdata[1:0];
         if (wr_stb && addr == `REG_ALERT) pol_ff <= wdata[3];
         if (wr_stb && addr == `REG_CONV) code_ff <= wdata[3:0];
         if (wr_stb && addr == `REG_THR_LO) lo_ff <= wdata[15:0];
         rr_ff <= afe_range_reset ? rr_ff + 16'h1 : 16'h0;
         low_ff <= alert_oe_n ? 16'h0 : low_ff + 16'h1;
         hold_ff <= (afe_channel != ch_ff) ? 16'h1 : hold_ff + 16'h1;
         ch_ff <= afe_channel;
      end
   end
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!arst_n);
   property p_off_idle;
      mode_ff == `MODE_OFF && !$past(afe_power) |-> !afe_power;
   endproperty
   a_off_idle: assert property (p_off_idle)
      else $error("front end woke in power-down");
   property p_order;
      $changed(afe_channel) |->
         afe_channel == $past(afe_channel) + 2'h1 || afe_channel == 2'h0;
   endproperty
   a_order: assert property (p_order)
      else $error("channel order broken");
   property p_conv_time;
      $changed(afe_channel) |->
         hold_ff >= CONV_BASE * ({12'h0, code_ff} + 16'h1);
   endproperty
   a_conv_time: assert property (p_conv_time)
      else $error("conversion too short");
   property p_alert_len;
      $rose(alert_oe_n) && fn_ff != `ALERT_FAULT && !pol_ff |->
         low_ff == `ALERT_PULSE_CYC;
   endproperty
   a_alert_len: assert property (p_alert_len)
      else $error("alert pulse width wrong");
   property p_rr_mode;
      $rose(afe_range_reset) |-> mode_ff == `MODE_FORCED;
   endproperty
   a_rr_mode: assert property (p_rr_mode)
      else $error("range reset outside forced mode");
   property p_rr_len;
      $fell(afe_range_reset) |-> rr_ff == RANGE_RESET;
   endproperty
   a_rr_len: assert property (p_rr_len)
      else $error("range reset length wrong");
   property p_lo_read;
      rd_stb && addr == `REG_THR_LO |=> rdata_ff == {16'h0, lo_ff};
   endproperty
   a_lo_read: assert property (p_lo_read)
      else $error("low threshold read wrong");
   property p_rd_quiet;
      !$past(rd_stb) |-> rdata_ff == 32'h0;
   endproperty
   a_rd_quiet: assert property (p_rd_quiet)
      else $error("read data outside read slot");
endmodule

// ===== afe_model.sv
// front end stand-in with fixed per-channel levels
`timescale 1ns/1ps
module afe_model (
   // control from the block
   input wire afe_power,
   input wire [1:0] afe_channel,
   // result to the block
   output wire [15:0] afe_sample,
   output wire [3:0] afe_range
);
   wire [15:0] level;
   // own level and range per channel
   assign level = {1'b0, afe_channel + 3'h1, 12'h0};
   assign afe_range = {2'h0, afe_channel} + 4'h1;
   // unpowered front end shows garbage
   assign afe_sample = afe_power ? level : ~level;
endmodule

// ===== color_sensor_measurement_control_tb_top.sv
// self-checking bench for the measurement control block
`timescale 1ns/1ps
`include "color_meas_defs.vh"
module color_sensor_measurement_control_tb_top;
   reg ref_clk = 1'b0, arst_n = 1'b0, wr_stb = 1'b0, rd_stb = 1'b0;
   reg alert_in = 1'b0, oe_ff = 1'b1;
   reg [3:0] addr = 4'h0;
   reg [31:0] wdata = 32'h0, d;
   reg [35:0] rows [0:6];
   wire [31:0] rdata;
   wire afe_power, afe_range_reset, alert_oe_n, alert_out;
   wire [1:0] afe_channel;
   wire [15:0] afe_sample;
   wire [3:0] afe_range;
   integer mismatches = 0, n_compared = 0, n_conv = 0;
   integer last = 0, cyc = 0, gap = 0, i;
   color_meas_ctrl #(.CONV_BASE(4), .RANGE_RESET(3), .WAKE(2)) dut_u (
      .ref_clk(ref_clk), .arst_n(arst_n), .addr(addr), .wdata(wdata),
      .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata_ff(rdata),
      .afe_power(afe_power), .afe_channel(afe_channel),
      .afe_range_reset(afe_range_reset), .afe_sample(afe_sample),
      .afe_range(afe_range), .alert_in(alert_in), .alert_out(alert_out),
      .alert_oe_n(alert_oe_n));
   afe_model afe_u (.afe_power(afe_power), .afe_channel(afe_channel),
      .afe_sample(afe_sample), .afe_range(afe_range));
   task end_sim;
      begin
         $display("compared %0d mismatched %0d", n_compared, mismatches);
         if (mismatches == 0 && n_compared > 0)
            $display("SIMULATION PASSED");
         else
            $display("SIMULATION FAILED");
         $finish;
      end
   endtask
   task chk(input [31:0] got, input [31:0] exp);
      begin
         n_compared = n_compared + 1;
         if (got !== exp) begin
            mismatches = mismatches + 1;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
         end
      end
   endtask
   task wr(input [3:0] a, input [31:0] v);
      begin
         @(posedge ref_clk);
         addr <= a;
         wdata <= v;
         wr_stb <= 1'b1;
         @(posedge ref_clk);
         wr_stb <= 1'b0;
      end
   endtask
   task rd(input [3:0] a);
      begin
         @(posedge ref_clk);
         addr <= a;
         rd_stb <= 1'b1;
         @(posedge ref_clk);
         rd_stb <= 1'b0;
         @(negedge ref_clk);
         d = rdata;
      end
   endtask
   function [31:0] res(input [1:0] ch, input integer m);
      reg [15:0] s;
      reg [3:0] f;
      integer j;
      begin
         s = {1'b0, ch + 3'h1, 12'h0};
         f = m[3:0];
         for (j = 0; j < 16; j = j + 1)
            f[j % 4] = f[j % 4] ^ s[j];
         res = {{2'h0, ch} + 4'h1, f, m[3:0], 4'h0, s};
      end
   endfunction
   task res_all(input integer n);
      integer c;
      begin
         for (c = 0; c < 4; c = c + 1) begin
            rd(`REG_RES0 + c[3:0]);
            chk(d, res(c[1:0], (n + 3 - c) / 4));
         end
      end
   endtask
   task shot;
      integer k;
      begin
         wr(`REG_TRIG, 32'h1);
         d = 32'h1;
         for (k = 0; k < 100 && d[0] !== 1'b0; k = k + 1)
            rd(`REG_TRIG);
         chk({31'h0, d[0]}, 32'h0);
      end
   endtask
   task wait_conv(input integer t);
      integer k;
      begin
         for (k = 0; k < 8000 && n_conv < t; k = k + 1)
            @(posedge ref_clk);
         chk({31'h0, n_conv >= t}, 32'h1);
      end
   endtask
   always @(posedge ref_clk) begin
      cyc = cyc + 1;
      if (gap > 0 && oe_ff === 1'b1 && alert_oe_n === 1'b0) begin
         if (last > 0)
            chk(cyc - last, gap);
         last = cyc;
         n_conv = n_conv + ((gap == 256) ? 4 : 1);
      end
      oe_ff = alert_oe_n;
   end
   initial begin
      forever #12.5 ref_clk = ~ref_clk;
   end
   initial begin
      repeat (20000) @(posedge ref_clk);
      mismatches = mismatches + 1;
      $display("unexpected at %0t: run hung", $time);
      end_sim;
   end
   initial begin
      rows[0] = {`REG_MODE, 32'h0};
      rows[1] = {`REG_CONV, 32'h0};
      rows[2] = {`REG_THR_LO, 32'h0};
      rows[3] = {`REG_THR_HI, 32'h0000_ffff};
      rows[4] = {`REG_FLAGS, 32'h0};
      rows[5] = {`REG_RES0, 32'h0};
      rows[6] = {4'hc, 32'h0};
      repeat (4) @(posedge ref_clk);
      arst_n <= 1'b1;
      wr(4'hc, 32'hffff_ffff);
      wr(`REG_TRIG, 32'h1);
      repeat (40) @(posedge ref_clk);
      for (i = 0; i < 7; i = i + 1) begin
         rd(rows[i][35:32]);
         chk(d, rows[i][31:0]);
      end
      chk({31'h0, afe_power}, 32'h0);
      chk({30'h0, alert_out, alert_oe_n}, 32'h1);
      $display("reset and power-down test done");
      wr(`REG_MODE, {30'h0, `MODE_ONESHOT});
      shot;
      res_all(4);
      $display("one-shot test done");
      wr(`REG_THR_LO, 32'h0000_1800);
      wr(`REG_THR_HI, 32'h0000_2800);
      wr(`REG_THR_CFG, 32'h6);
      wr(`REG_MODE, {30'h0, `MODE_FORCED});
      shot;
      rd(`REG_FLAGS);
      chk(d, 32'h0);
      shot;
      chk({31'h0, alert_oe_n}, 32'h0);
      rd(`REG_FLAGS);
      chk(d, 32'h2);
      rd(`REG_FLAGS);
      chk(d, 32'h0);
      chk({31'h0, alert_oe_n}, 32'h1);
      wr(`REG_ALERT, 32'h8);
      @(negedge ref_clk);
      chk({31'h0, alert_oe_n}, 32'h0);
      res_all(12);
      $display("threshold test done");
      wr(`REG_ALERT, 32'h4);
      wr(`REG_MODE, 32'h6);
      alert_in <= 1'b1;
      repeat (3) @(posedge ref_clk);
      alert_in <= 1'b0;
      repeat (100) @(posedge ref_clk);
      chk({31'h0, afe_power}, 32'h1);
      res_all(16);
      $display("pin trigger test done");
      wr(`REG_MODE, 32'h0);
      wr(`REG_CONV, 32'hf);
      wr(`REG_ALERT, {30'h0, `ALERT_EACH});
      n_conv = 16;
      gap = 64;
      wr(`REG_MODE, {30'h0, `MODE_CONT});
      wait_conv(84);
      wr(`REG_ALERT, {30'h0, `ALERT_SET});
      gap = 256;
      wait_conv(96);
      wr(`REG_ALERT, {30'h0, `ALERT_EACH});
      gap = 64;
      wait_conv(99);
      wr(`REG_MODE, 32'h0);
      repeat (200) @(posedge ref_clk);
      chk({31'h0, afe_power}, 32'h0);
      res_all(n_conv);
      $display("continuous test done");
      end_sim;
   end
endmodule
bind color_meas_ctrl color_meas_checker #(.CONV_BASE(CONV_BASE),
   .RANGE_RESET(RANGE_RESET)) chk_u (.ref_clk(ref_clk), .arst_n(arst_n),
   .addr(addr), .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb),
   .rdata_ff(rdata_ff), .afe_power(afe_power), .afe_channel(afe_channel),
   .afe_range_reset(afe_range_reset), .alert_oe_n(alert_oe_n));
